// ---- hw/sfw_core.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sfw_defs.svh"
// Behaviour
// - Word read takes even address; two dummy clocks follow the mode byte.
// - Read address advances by one after every byte shifted out.
// - Word read is taken only while the quad permit bit is set.
// - Continuation bits 10 make the next word read start at the address.
// - Other continuation bits return decoding to a full command byte.
// - With wrap on, output wraps inside the aligned section until select rises.
// - Wrap-off bit zero enables wrap; one disables it and is the reset value.
// - Wrap size field selects 8, 16, 32 or 64 byte sections.
// - Stored wrap governs all later standard-mode word reads until changed.
// - Octal word read needs aligned address, no dummy, permit bit set.
// - Octal mode byte upper nibble decides continuation; lower nibble ignored.
// - Read-parameter command sets dummy clocks 10, 4, 6 or 8.
// - Read-parameter command sets wrap length 8, 16, 32 or 64.
// - Read parameters survive a change into four-wire command mode.
// - Four-wire wrap read is a fast read that wraps using read parameters.
// - Write enable sets the latch; erases need the latch set beforehand.
// - Page clear takes three address bytes and clears the addressed page.
// - Sector clear takes three address bytes and clears the addressed sector.
// - Select must rise right after the last address bit or erase is dropped.
// - Valid erase starts on select rise; busy during it; latch clears early.
// - Erase of a protected target is not executed.
module sfw_core #(
  parameter int unsigned PAGE_CLEAR_CYC = `SFW_PAGE_CLEAR_CYC,
  parameter int unsigned SECT_CLEAR_CYC = `SFW_SECT_CLEAR_CYC,
  parameter int unsigned BUSY_W = 24
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  input wire logic quad_io_permit_bit_i,
  input wire logic four_wire_command_mode_i,
  input wire logic [4:0] protect_level_bits_i,
  input wire logic region_protected_i,
  input wire logic [7:0] rd_data_i,
  output logic [23:0] mem_addr_o,
  output logic erase_start_o,
  output logic erase_sector_o,
  output logic write_latch_flag_o,
  output logic busy_flag_o,
  output logic cont_mode_o,
  output logic wrap_off_bit_o,
  output logic [1:0] wrap_size_field_o,
  output logic [1:0] qpi_dummy_field_o,
  output logic [1:0] qpi_wrap_field_o
);
  import sfw_pkg::*;
  // ========================================================================
  // Helpers
  function automatic logic [5:0] dummy_clks(input logic [1:0] f);
    case (f)
      2'h0: return `SFW_QDUMMY_00;
      2'h1: return `SFW_QDUMMY_01;
      2'h2: return `SFW_QDUMMY_10;
      default: return `SFW_QDUMMY_11;
    endcase
  endfunction
  function automatic logic [23:0] next_addr(input logic [23:0] a, input logic en,
                                            input logic [1:0] sz);
    logic [23:0] m;
    logic [23:0] inc;
    m = (`SFW_WRAP_BASE_MASK << sz) | `SFW_WRAP_BASE_MASK;
    inc = a + `SFW_ADDR_ONE;
    if (en) begin
      return (a & ~m) | (inc & m);
    end
    return inc;
  endfunction
  // ========================================================================
  // Pin synchronisers
  // The serial clock is oversampled, so every pin takes two flops before use.
  logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  sfw_nib_t io_s1_q, io_s2_q;
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      sclk_s1_q <= 1'h0;
      sclk_s2_q <= 1'h0;
      sclk_s3_q <= 1'h0;
      cs_s1_q <= 1'h1;
      cs_s2_q <= 1'h1;
      cs_s3_q <= 1'h1;
      io_s1_q <= 4'h0;
      io_s2_q <= 4'h0;
    end else if (ce_i) begin
      sclk_s1_q <= sclk_i;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      cs_s1_q <= cs_n_i;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      io_s1_q <= io_i;
      io_s2_q <= io_s1_q;
    end
  end
  logic cs_fall, cs_rise, sck_rise, sck_fall;
  assign cs_fall = cs_s3_q & ~cs_s2_q;
  assign cs_rise = ~cs_s3_q & cs_s2_q;
  assign sck_rise = ~cs_s2_q & ~cs_s3_q & sclk_s2_q & ~sclk_s3_q;
  assign sck_fall = ~cs_s2_q & ~cs_s3_q & ~sclk_s2_q & sclk_s3_q;
  // ========================================================================
  // Frame decoding
  sfw_phase_t phase_q;
  logic [7:0] cmd_q, cont_cmd_q;
  logic [31:0] sh_q, sh_nx;
  logic [5:0] cnt_q, tgt_q, cnt_nx;
  logic wide_q, cont_q, wel_q, busy_q, nib_q, sector_q, start_q;
  logic wrap_off_q, wrap_act_q;
  logic [1:0] wrap_size_q, pdummy_q, pwrap_q, wrap_len_q;
  logic done, is_erase, cmd_ok, erase_ok;
  assign sh_nx = wide_q ? {sh_q[27:0], io_s2_q} : {sh_q[30:0], io_s2_q[0]};
  assign cnt_nx = cnt_q + (wide_q ? `SFW_QUAD_STEP : `SFW_SINGLE_STEP);
  assign done = sck_rise && (cnt_nx == tgt_q);
  assign is_erase = (cmd_q == `SFW_CMD_PAGE_CLR) || (cmd_q == `SFW_CMD_SECT_CLR);
  assign erase_ok = cs_rise && (phase_q == SFW_ARM) && wel_q &&
                    !((protect_level_bits_i != 5'h00) && region_protected_i);
  // Decides whether a freshly received command byte other than write enable is taken at all.
  always_comb begin
    cmd_ok = 1'b0;
    if (!busy_q) begin
      case (sh_nx[7:0])
        `SFW_CMD_WORD_RD, `SFW_CMD_OCT_RD: cmd_ok = quad_io_permit_bit_i;
        `SFW_CMD_WRAP_RD, `SFW_CMD_SET_PARAM: cmd_ok = four_wire_command_mode_i;
        `SFW_CMD_SET_WRAP: cmd_ok = !four_wire_command_mode_i;
        `SFW_CMD_PAGE_CLR, `SFW_CMD_SECT_CLR: cmd_ok = 1'b1;
        default: cmd_ok = 1'b0;
      endcase
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      phase_q <= SFW_IDLE;
      cmd_q <= 8'h00;
      sh_q <= 32'h0000_0000;
      cnt_q <= 6'h00;
      tgt_q <= `SFW_BYTE_BITS;
      wide_q <= 1'b0;
    end else if (ce_i) begin
      if (cs_rise) begin
        phase_q <= SFW_IDLE;
      end else if (cs_fall) begin
        cnt_q <= 6'h00;
        if (cont_q) begin
          phase_q <= SFW_ADDR;
          cmd_q <= cont_cmd_q;
          tgt_q <= `SFW_ADDR_BITS;
          wide_q <= 1'b1;
        end else begin
          phase_q <= SFW_CMD;
          tgt_q <= `SFW_BYTE_BITS;
          wide_q <= four_wire_command_mode_i;
        end
      end else if (sck_rise) begin
        sh_q <= sh_nx;
        cnt_q <= cnt_nx;
        if (done) begin
          cnt_q <= 6'h00;
          case (phase_q)
            SFW_CMD: begin
              cmd_q <= sh_nx[7:0];
              tgt_q <= (sh_nx[7:0] == `SFW_CMD_SET_PARAM) ? `SFW_BYTE_BITS : `SFW_ADDR_BITS;
              wide_q <= four_wire_command_mode_i || (sh_nx[7:0] == `SFW_CMD_WORD_RD) ||
                        (sh_nx[7:0] == `SFW_CMD_OCT_RD);
              if (!cmd_ok) begin
                phase_q <= SFW_SKIP;
              end else if (sh_nx[7:0] == `SFW_CMD_SET_PARAM) begin
                phase_q <= SFW_PARAM;
              end else begin
                phase_q <= SFW_ADDR;
              end
            end
            SFW_ADDR: begin
              if (is_erase) begin
                phase_q <= SFW_ARM;
              end else if (cmd_q == `SFW_CMD_SET_WRAP) begin
                phase_q <= SFW_PARAM;
                tgt_q <= `SFW_BYTE_BITS;
              end else if (cmd_q == `SFW_CMD_WRAP_RD) begin
                phase_q <= SFW_DUMMY;
                tgt_q <= dummy_clks(pdummy_q);
                wide_q <= 1'b0;
              end else begin
                phase_q <= SFW_MODE;
                tgt_q <= `SFW_BYTE_BITS;
              end
            end
            SFW_MODE: begin
              if (cmd_q == `SFW_CMD_OCT_RD) begin
                phase_q <= SFW_DATA;
              end else begin
                phase_q <= SFW_DUMMY;
                tgt_q <= `SFW_WORD_DUMMY;
                wide_q <= 1'b0;
              end
            end
            SFW_DUMMY: phase_q <= SFW_DATA;
            SFW_PARAM: phase_q <= SFW_SKIP;
            SFW_ARM: phase_q <= SFW_SKIP;
            default: phase_q <= phase_q;
          endcase
        end else if (phase_q == SFW_ARM) begin
          phase_q <= SFW_SKIP;
        end
      end
    end
  end
  // ========================================================================
  // Continuation mode
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      cont_q <= 1'b0;
      cont_cmd_q <= 8'h00;
    end else if (ce_i) begin
      if (done && (phase_q == SFW_MODE)) begin
        cont_q <= (sh_nx[5:4] == `SFW_CONT_KEEP);
        cont_cmd_q <= cmd_q;
      end else if (done && (phase_q == SFW_CMD)) begin
        cont_q <= 1'b0;
      end
    end
  end
  // ========================================================================
  // Stored wrap and read parameters
  // Nothing here looks at the four-wire mode pin, so a mode change keeps them.
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      wrap_off_q <= `SFW_WRAP_OFF_RST;
      wrap_size_q <= `SFW_FIELD_RST;
      pdummy_q <= `SFW_FIELD_RST;
      pwrap_q <= `SFW_FIELD_RST;
    end else if (ce_i && done && (phase_q == SFW_PARAM)) begin
      if (cmd_q == `SFW_CMD_SET_WRAP) begin
        wrap_off_q <= sh_nx[`SFW_WRAP_OFF_POS];
        wrap_size_q <= sh_nx[`SFW_WRAP_SIZE_HI:`SFW_WRAP_SIZE_LO];
      end else begin
        pdummy_q <= sh_nx[`SFW_PDUMMY_HI:`SFW_PDUMMY_LO];
        pwrap_q <= sh_nx[`SFW_PWRAP_HI:`SFW_PWRAP_LO];
      end
    end
  end
  // ========================================================================
  // Read address and data output
  logic [23:0] addr_q;
  sfw_nib_t lo_q;
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      addr_q <= 24'h00_0000;
      wrap_act_q <= 1'b0;
      wrap_len_q <= `SFW_FIELD_RST;
      nib_q <= 1'b0;
      lo_q <= 4'h0;
      io_o <= 4'h0;
      io_oe_o <= 4'h0;
    end else if (ce_i) begin
      if (cs_rise || cs_fall) begin
        io_oe_o <= 4'h0;
        nib_q <= 1'b0;
      end else if (done && (phase_q == SFW_ADDR)) begin
        addr_q <= sh_nx[23:0];
        if (cmd_q == `SFW_CMD_WRAP_RD) begin
          wrap_act_q <= 1'b1;
          wrap_len_q <= pwrap_q;
        end else begin
          wrap_act_q <= (cmd_q == `SFW_CMD_WORD_RD) && !four_wire_command_mode_i &&
                        !wrap_off_q;
          wrap_len_q <= wrap_size_q;
        end
      end else if (sck_fall && (phase_q == SFW_DATA)) begin
        io_oe_o <= 4'hF;
        nib_q <= !nib_q;
        if (!nib_q) begin
          io_o <= rd_data_i[7:4];
          lo_q <= rd_data_i[3:0];
        end else begin
          io_o <= lo_q;
          addr_q <= next_addr(addr_q, wrap_act_q, wrap_len_q);
        end
      end
    end
  end
  // ========================================================================
  // Write latch, erase start and busy timer
  logic [BUSY_W-1:0] busy_cnt_q;
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      wel_q <= 1'b0;
      busy_q <= 1'b0;
      busy_cnt_q <= '0;
      sector_q <= 1'b0;
      start_q <= 1'b0;
    end else if (ce_i) begin
      start_q <= erase_ok;
      if (done && (phase_q == SFW_CMD) && !busy_q && (sh_nx[7:0] == `SFW_CMD_WREN)) begin
        wel_q <= 1'b1;
      end
      if (erase_ok) begin
        busy_q <= 1'b1;
        wel_q <= 1'b0;
        sector_q <= (cmd_q == `SFW_CMD_SECT_CLR);
        busy_cnt_q <= (cmd_q == `SFW_CMD_SECT_CLR) ? BUSY_W'(SECT_CLEAR_CYC) :
                                                     BUSY_W'(PAGE_CLEAR_CYC);
      end else if (busy_q) begin
        busy_cnt_q <= busy_cnt_q - BUSY_W'(1);
        busy_q <= (busy_cnt_q != BUSY_W'(1));
      end
    end
  end
  assign mem_addr_o = addr_q;
  assign erase_start_o = start_q;
  assign erase_sector_o = sector_q;
  assign write_latch_flag_o = wel_q;
  assign busy_flag_o = busy_q;
  assign cont_mode_o = cont_q;
  assign wrap_off_bit_o = wrap_off_q;
  assign wrap_size_field_o = wrap_size_q;
  assign qpi_dummy_field_o = pdummy_q;
  assign qpi_wrap_field_o = pwrap_q;
  // ========================================================================
  // Assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i || !ce_i);
  sequence s_word_cmd_refused;
    done && (phase_q == SFW_CMD) && (sh_nx[7:0] == `SFW_CMD_WORD_RD) && !quad_io_permit_bit_i;
  endsequence
  a_word_permit_chk: assert property (s_word_cmd_refused |=> phase_q == SFW_SKIP)
    else $error("word read taken without permit");
  a_word_dummy_two: assert property (done && phase_q == SFW_MODE && cmd_q == `SFW_CMD_WORD_RD
    |=> phase_q == SFW_DUMMY && tgt_q == `SFW_WORD_DUMMY)
    else $error("word read dummy count wrong");
  a_cont_addr_entry: assert property (cs_fall && cont_q |=> phase_q == SFW_ADDR && wide_q)
    else $error("continuation did not skip command");
  a_cont_leave: assert property (done && phase_q == SFW_MODE && sh_nx[5:4] != `SFW_CONT_KEEP
    |=> !cont_q)
    else $error("continuation kept on wrong bits");
  a_wrap_inside: assert property (sck_fall && phase_q == SFW_DATA && nib_q && wrap_act_q
    |=> addr_q[23:6] == $past(addr_q[23:6]))
    else $error("wrap left its section");
  a_param_hold: assert property (four_wire_command_mode_i != $past(four_wire_command_mode_i)
    && !(done && phase_q == SFW_PARAM) |=> $stable(pdummy_q) && $stable(pwrap_q))
    else $error("read parameters lost on mode change");
  a_wel_after_wren: assert property (done && phase_q == SFW_CMD && !busy_q &&
    sh_nx[7:0] == `SFW_CMD_WREN |=> wel_q)
    else $error("write enable not latched");
  a_erase_needs_arm: assert property ($rose(busy_q) |-> $past(phase_q) == SFW_ARM
    && $past(wel_q) && $past(cs_rise))
    else $error("erase started without proper framing");
  a_erase_busy_on: assert property (erase_ok |=> busy_q && !wel_q ##0 start_q)
    else $error("erase start did not raise busy");
  a_erase_protect: assert property (cs_rise && phase_q == SFW_ARM && region_protected_i &&
    protect_level_bits_i != 5'h00 |=> !$rose(busy_q))
    else $error("protected region erased");
endmodule // sfw_core
`default_nettype wire

// ---- hw/sfw_defs.svh ----
`ifndef SFW_DEFS_SVH
`define SFW_DEFS_SVH
// ==========================================================================
// Command codes
`define SFW_CMD_WREN 8'h06
`define SFW_CMD_WORD_RD 8'hE7
`define SFW_CMD_OCT_RD 8'hE3
`define SFW_CMD_SET_PARAM 8'hC0
`define SFW_CMD_WRAP_RD 8'h0C
`define SFW_CMD_SET_WRAP 8'h77
`define SFW_CMD_PAGE_CLR 8'h81
`define SFW_CMD_SECT_CLR 8'h20
// ==========================================================================
// Frame lengths, counted in bits received
`define SFW_BYTE_BITS 6'h08
`define SFW_ADDR_BITS 6'h18
`define SFW_QUAD_STEP 6'h04
`define SFW_SINGLE_STEP 6'h01
`define SFW_WORD_DUMMY 6'h02
`define SFW_CONT_KEEP 2'h2
// ==========================================================================
// Field positions and reset values
`define SFW_WRAP_OFF_POS 4
`define SFW_WRAP_SIZE_HI 6
`define SFW_WRAP_SIZE_LO 5
`define SFW_PDUMMY_HI 5
`define SFW_PDUMMY_LO 4
`define SFW_PWRAP_HI 1
`define SFW_PWRAP_LO 0
`define SFW_WRAP_OFF_RST 1'h1
`define SFW_FIELD_RST 2'h0
`define SFW_WRAP_BASE_MASK 24'h000007
`define SFW_ADDR_ONE 24'h000001
// ==========================================================================
// Dummy clocks per read-parameter encoding
`define SFW_QDUMMY_00 6'h0A
`define SFW_QDUMMY_01 6'h04
`define SFW_QDUMMY_10 6'h06
`define SFW_QDUMMY_11 6'h08
// ==========================================================================
// Timing
`define SFW_CLK_PERIOD_NS 4
`define SFW_PAGE_CLEAR_TIME_US 20
`define SFW_SECT_CLEAR_TIME_US 50
`define SFW_PAGE_CLEAR_CYC ((`SFW_PAGE_CLEAR_TIME_US * 1000 + `SFW_CLK_PERIOD_NS - 1) / `SFW_CLK_PERIOD_NS)
`define SFW_SECT_CLEAR_CYC ((`SFW_SECT_CLEAR_TIME_US * 1000 + `SFW_CLK_PERIOD_NS - 1) / `SFW_CLK_PERIOD_NS)
`endif

// ---- hw/sfw_pkg.sv ----
// ==========================================================================
// Shared types
package sfw_pkg;
  typedef enum logic [3:0] {
    SFW_IDLE  = 4'h0,
    SFW_CMD   = 4'h1,
    SFW_ADDR  = 4'h3,
    SFW_MODE  = 4'h2,
    SFW_DUMMY = 4'h6,
    SFW_DATA  = 4'h7,
    SFW_PARAM = 4'h5,
    SFW_ARM   = 4'h4,
    SFW_SKIP  = 4'hC
  } sfw_phase_t;
  typedef logic [3:0] sfw_nib_t;
endpackage : sfw_pkg

// ---- verification/sfw_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Quad serial host model
module sfw_host_model (
  output var logic sclk_o,
  output var logic cs_n_o,
  output var logic [3:0] io_o,
  output var logic [3:0] io_oe_o,
  input wire logic [3:0] io_i
);
  localparam time HALF = 32ns;
  logic [7:0] rx_byte;
  event rx_ev;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    io_o = 4'h0;
    io_oe_o = 4'h0;
  end
  task automatic start();
    cs_n_o = 1'b0;
    #HALF;
  endtask
  // Released lines flip every clock, so a stale level can never pass for device data.
  task automatic tick(input logic [3:0] nib, input logic [3:0] oe, output logic [3:0] got);
    sclk_o = 1'b0;
    io_oe_o = oe;
    io_o = (nib & oe) | (~io_o & ~oe);
    #HALF;
    sclk_o = 1'b1;
    got = io_i;
    #HALF;
  endtask
  task automatic send(input logic [31:0] v, input int nbits, input int w);
    logic [3:0] g;
    for (int i = nbits - w; i >= 0; i -= w) begin
      if (w == 4) tick(v[i +: 4], 4'hF, g);
      else tick({3'h0, v[i]}, 4'h1, g);
    end
  endtask
  task automatic idle(input int n);
    logic [3:0] g;
    for (int k = 0; k < n; k++) tick(4'h0, 4'h0, g);
  endtask
  task automatic rd(input int n);
    logic [3:0] hi;
    logic [3:0] lo;
    io_oe_o = 4'h0;
    #4ns;
    for (int k = 0; k < n; k++) begin
      tick(4'h0, 4'h0, hi);
      tick(4'h0, 4'h0, lo);
      rx_byte = {hi, lo};
      ->rx_ev;
    end
  endtask
  // The clock rests low between frames; select rises only after a whole last bit.
  task automatic stop();
    sclk_o = 1'b0;
    io_oe_o = 4'h0;
    #HALF;
    cs_n_o = 1'b1;
    #(2 * HALF);
  endtask
  task automatic cont_off();
    start();
    send(32'hFF, 8, 1);
    stop();
  endtask
endmodule // sfw_host_model
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int unsigned PCYC = 400;
  localparam int unsigned SCYC = 600;
  localparam int unsigned LIMIT = 90000;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic permit = 1'b0;
  logic qmode = 1'b0;
  logic prot = 1'b0;
  logic [4:0] plev = 5'h00;
  logic sclk, cs_n, e_start, e_sect, latch, busy, cont, w_off;
  logic [3:0] h_io, h_oe, d_io, d_oe, io_bus;
  logic [1:0] w_size, q_dum, q_wrap;
  logic [7:0] rd_data;
  logic [23:0] mem_addr, st_addr;
  logic st_sect;
  logic oe_seen = 1'b0;
  logic [7:0] exp_q[$];
  int fail_count = 0;
  int checks = 0;
  int starts = 0;
  int cycles = 0;
  int run = 0;
  int last_run = 0;
  // Host wins a clash on the wire model; the contention monitor below reports it.
  assign io_bus = ((h_oe | ~d_oe) & h_io) | (~h_oe & d_oe & d_io);
  assign rd_data = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h5A;
  sfw_core #(.PAGE_CLEAR_CYC(PCYC), .SECT_CLEAR_CYC(SCYC)) dut (
    .mclk_i(mclk), .rstn_i(rstn), .ce_i(1'b1), .sclk_i(sclk), .cs_n_i(cs_n), .io_i(io_bus),
    .io_o(d_io), .io_oe_o(d_oe), .quad_io_permit_bit_i(permit),
    .four_wire_command_mode_i(qmode), .protect_level_bits_i(plev), .region_protected_i(prot),
    .rd_data_i(rd_data), .mem_addr_o(mem_addr), .erase_start_o(e_start),
    .erase_sector_o(e_sect), .write_latch_flag_o(latch), .busy_flag_o(busy), .cont_mode_o(cont),
    .wrap_off_bit_o(w_off), .wrap_size_field_o(w_size), .qpi_dummy_field_o(q_dum),
    .qpi_wrap_field_o(q_wrap));
  sfw_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(h_io), .io_oe_o(h_oe), .io_i(io_bus));
  initial begin
    forever #2 mclk = ~mclk;
  end
  // ==========================================================================
  // Checking
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    if (fail_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (e_start === 1'b1) begin
      starts++;
      st_addr = mem_addr;
      st_sect = e_sect;
    end
    if (busy === 1'b1) run++;
    else if (run != 0) begin
      last_run = run;
      run = 0;
    end
    if (rstn && d_oe != 4'h0) oe_seen = 1'b1;
    if (rstn && (h_oe & d_oe) != 4'h0) chk("line contention", 32'h0, 32'h1);
    if (cycles == LIMIT) begin
      chk("timeout", 32'h0, 32'h1);
      stop_test();
    end
  end
  initial begin
    forever begin
      @(host.rx_ev);
      if (exp_q.size() == 0) chk("unexpected byte", 32'hFFFFFFFF, {24'h0, host.rx_byte});
      else chk("read byte", {24'h0, exp_q.pop_front()}, {24'h0, host.rx_byte});
    end
  end
  // ==========================================================================
  // Frames
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // A length of zero gives an all-ones mask, which is a plain increment.
  task automatic expect_rd(input logic [23:0] a, input int n, input int len);
    logic [23:0] m;
    m = 24'(len - 1);
    for (int k = 0; k < n; k++) begin
      exp_q.push_back(a[7:0] ^ a[15:8] ^ 8'h5A);
      a = (a & ~m) | ((a + 24'h1) & m);
    end
  endtask
  task automatic qrd(input logic [7:0] c, input logic skip, input logic [23:0] a,
      input logic [7:0] mode, input int dum, input int n, input int len, input logic ec);
    cyc(1);
    host.start();
    if (!skip) host.send({24'h0, c}, 8, qmode ? 4 : 1);
    host.send({8'h0, a}, 24, 4);
    host.send({24'h0, mode}, 8, 4);
    host.idle(dum);
    expect_rd(a, n, len);
    host.rd(n);
    host.stop();
    cyc(8);
    chk("continuation", {31'h0, ec}, {31'h0, cont});
  endtask
  task automatic cmd2(input logic [7:0] c, input logic [7:0] p, input int nb);
    cyc(1);
    host.start();
    host.send({24'h0, c}, 8, qmode ? 4 : 1);
    host.send({24'h0, p}, nb, qmode ? 4 : 1);
    host.stop();
    cyc(8);
  endtask
  task automatic set_wrap(input logic [7:0] wb);
    cyc(1);
    host.start();
    host.send(32'h77, 8, 1);
    host.send($urandom, 24, 1);
    host.send({24'h0, wb}, 8, 1);
    host.stop();
    cyc(8);
    chk("wrap bits", {29'h0, wb[6:4]}, {29'h0, w_size, w_off});
  endtask
  task automatic erase(input logic [7:0] c, input logic [23:0] a, input int nb, input logic ok);
    int s0;
    logic l0;
    s0 = starts;
    l0 = latch;
    cyc(1);
    host.start();
    host.send({24'h0, c}, 8, 1);
    host.send(nb == 25 ? {7'h0, a, 1'b0} : {8'h0, a} >> (24 - nb), nb, 1);
    host.stop();
    cyc(8);
    chk("erase pulses", {31'h0, ok}, 32'(starts - s0));
    if (ok) begin
      chk("erase target", {8'h0, a}, {8'h0, st_addr});
      chk("erase kind", {31'h0, c == 8'h20}, {31'h0, st_sect});
      chk("busy and latch", 32'h2, {30'h0, busy, latch});
      cmd2(8'h06, 8'h00, 0);
      chk("latch while busy", 32'h0, {31'h0, latch});
      for (int k = 0; k < 700 && busy !== 1'b0; k++) cyc(1);
      // The monitor logs a finished run only at the edge after the loop first sees busy low.
      cyc(1);
      chk("busy length", 32'h1, 32'(last_run + 2 >= (c == 8'h20 ? SCYC : PCYC)
          && last_run <= (c == 8'h20 ? SCYC : PCYC) + 1));
    end else begin
      chk("no erase", {30'h0, l0, 1'b0}, {30'h0, latch, busy});
    end
  endtask
  // ==========================================================================
  // Sequence
  initial begin
    logic [23:0] a;
    int len;
    void'($urandom(13));
    cyc(2);
    rstn = 1'b1;
    cyc(4);
    chk("reset state", 32'h200, {22'h0, w_off, w_size, q_dum, q_wrap, latch, busy, cont});
    qrd(8'hE7, 0, 24'h000100, 8'h20, 2, 0, 0, 1'b0);
    chk("refused output", 32'h0, {31'h0, oe_seen});
    permit = 1'b1;
    a = 24'($urandom) & 24'hFFFFFE;
    qrd(8'hE7, 0, a, 8'h00, 2, 6, 0, 1'b0);
    for (int s = 0; s < 4; s++) begin
      len = 8 << s;
      set_wrap({1'b0, 2'(s), 1'b0, 4'($urandom)});
      a = (24'($urandom) & ~24'(len - 1)) | 24'(len - 4);
      qrd(8'hE7, 0, a, 8'h20, 2, len + 2, len, 1'b1);
      qrd(8'hE7, 1, a ^ 24'h013300, 8'hF0, 2, len + 2, len, 1'b0);
    end
    set_wrap(8'h70);
    a = (24'($urandom) & 24'hFFFFC0) | 24'h00003C;
    qrd(8'hE7, 0, a, 8'h00, 2, 8, 0, 1'b0);
    a = 24'($urandom) & 24'hFFFFF0;
    qrd(8'hE3, 0, a, 8'h2F, 0, 20, 0, 1'b1);
    qrd(8'hE3, 1, a + 24'h000040, 8'hD0, 0, 3, 0, 1'b0);
    qrd(8'hE7, 0, a, 8'h20, 2, 2, 0, 1'b1);
    cyc(1);
    host.cont_off();
    cyc(8);
    chk("continuation", 32'h0, {31'h0, cont});
    qmode = 1'b1;
    for (int e = 0; e < 4; e++) begin
      len = 8 << (3 - e);
      cmd2(8'hC0, {2'h0, 2'(e), 2'h0, 2'(3 - e)}, 8);
      chk("read params", {28'h0, 2'(e), 2'(3 - e)}, {28'h0, q_dum, q_wrap});
      a = (24'($urandom) & ~24'(len - 1)) | 24'(len - 3);
      qrd(8'h0C, 0, a, 8'h00, (e == 0) ? 8 : 2 * e, 6, len, 1'b0);
    end
    cmd2(8'h77, 8'h00, 32);
    chk("wrap kept", 32'h7, {29'h0, w_size, w_off});
    qmode = 1'b0;
    cmd2(8'hC0, 8'h11, 8);
    qmode = 1'b1;
    cyc(4);
    chk("params kept", 32'hC, {28'h0, q_dum, q_wrap});
    qmode = 1'b0;
    a = 24'($urandom);
    erase(8'h81, a, 24, 1'b0);
    cmd2(8'h06, 8'h00, 0);
    chk("latch set", 32'h1, {31'h0, latch});
    erase(8'h81, a, 25, 1'b0);
    erase(8'h81, a, 23, 1'b0);
    erase(8'h81, a, 24, 1'b1);
    cmd2(8'h06, 8'h00, 0);
    prot = 1'b1;
    plev = 5'(1 + $urandom % 31);
    erase(8'h20, a, 24, 1'b0);
    prot = 1'b0;
    plev = 5'h00;
    erase(8'h20, a ^ 24'h00F000, 24, 1'b1);
    chk("pending reads", 32'h0, 32'(exp_q.size()));
    stop_test();
  end
endmodule // tb
`default_nettype wire
